/* File: mode_switch_error_check.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Power-up in virtual mode with bad backup sum or no homing: code 12010, homing request.
// - Encoder communication fault at amplifier power-up: code 12020, homing needed again.
// - Encoder step above half a turn per sampling interval: code 12030, homing request.
// - Encoder and feedback positions differ within valid encoder bits: code 12040.
// - Request rises while any axis start-accept flag set: stay real, code 0001.
// - Request falls while any axis start-accept flag set: stay virtual, code 0100.
// - Request rises with no mechanical program registered: rejected, code 0200.
// - Request rises with mismatched axis numbers: rejected, code 0200.
// - Request rises with controller or motion processor not ready: rejected, code 0201.
// - Request rises with all-axes servo-on command clear: rejected, code 0202.
// - Codes 0201 and 0202 leave the faulting-axis registers untouched.
module mode_switch_error_check #(
    parameter int SAMPLE_CYCLES = mode_check_pkg::SAMPLE_CYCLES_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Axis side
    input wire logic amp_power_on,
    input wire logic encoder_comm_fault,
    input wire logic backup_checksum_fail,
    input wire logic [31:0] encoder_position,
    input wire logic [31:0] feedback_position,
    // Status outputs
    output logic homing_request,
    output logic virtual_mode,
    output logic irq
);
    import mode_check_pkg::*;

    // ********************************************************
    // Registers
    // ********************************************************
    logic [CTL_WIDTH-1:0] control;
    logic [31:0] axis_start_accept_flags;
    logic [15:0] mode_switch_error_code;
    logic [15:0] error_axis_info_low;
    logic [15:0] error_axis_info_high;
    logic [15:0] module_error_code;
    logic [5:0] enc_bits;
    logic [31:0] half_turn;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    op_mode_t mode;
    logic homed;
    logic req_prev;
    logic amp_on_prev;

    // Synchronised pins, all read by the supervision; only amp_on_s is also read by the status register.
    logic amp_on_s;
    logic comm_fault_s;
    logic checksum_fail_s;

    // ********************************************************
    // Bus slave
    // ********************************************************
    logic d_wr;
    logic d_rd;
    logic rd_ready;
    logic [7:0] d_addr;
    logic [31:0] rd_mux;
    wire accept = hsel && htrans[1] && hready;
    wire wr_fire = d_wr;
    wire wr_control = wr_fire && (d_addr == OFS_CONTROL);
    wire wr_start = wr_fire && (d_addr == OFS_START_ACCEPT);
    wire wr_switch_err = wr_fire && (d_addr == OFS_SWITCH_ERROR);
    wire wr_module_err = wr_fire && (d_addr == OFS_MODULE_ERROR);
    wire wr_enc_bits = wr_fire && (d_addr == OFS_ENC_BITS);
    wire wr_half_turn = wr_fire && (d_addr == OFS_HALF_TURN);
    wire wr_irq_status = wr_fire && (d_addr == OFS_IRQ_STATUS);
    wire wr_irq_mask = wr_fire && (d_addr == OFS_IRQ_MASK);
    wire homing_done = wr_control && hwdata[CTL_HOMING_DONE] && (mode == MODE_REAL);

    // A read takes one wait state so that a write in the preceding data phase is always seen.
    assign hreadyout = !d_rd || rd_ready;
    assign hresp = 1'b0;

    always_comb begin
        unique case (d_addr)
            OFS_CONTROL: rd_mux = {26'h0, control};
            OFS_START_ACCEPT: rd_mux = axis_start_accept_flags;
            OFS_STATE: rd_mux = {28'h0, amp_on_s, homed, homing_request, mode == MODE_VIRTUAL};
            OFS_SWITCH_ERROR: rd_mux = {16'h0, mode_switch_error_code};
            OFS_INFO_LOW: rd_mux = {16'h0, error_axis_info_low};
            OFS_INFO_HIGH: rd_mux = {16'h0, error_axis_info_high};
            OFS_MODULE_ERROR: rd_mux = {16'h0, module_error_code};
            OFS_ENC_BITS: rd_mux = {26'h0, enc_bits};
            OFS_HALF_TURN: rd_mux = half_turn;
            OFS_IRQ_STATUS: rd_mux = {29'h0, irq_status};
            OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            d_wr <= 1'b0;
            d_rd <= 1'b0;
            d_addr <= 8'h00;
            rd_ready <= 1'b0;
            hrdata <= 32'h0;
        end else begin
            d_wr <= accept ? hwrite : (hreadyout ? 1'b0 : d_wr);
            d_rd <= accept ? !hwrite : (hreadyout ? 1'b0 : d_rd);
            d_addr <= accept ? ((haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF) : d_addr;
            rd_ready <= d_rd && !rd_ready;
            hrdata <= (d_rd && !rd_ready) ? rd_mux : hrdata;
        end
    end

    // ********************************************************
    // Axis pins
    // ********************************************************
    axis_check_if ck ();

    pin_sync #(.WIDTH(3)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in({amp_power_on, encoder_comm_fault, backup_checksum_fail}),
        .pin_out({amp_on_s, comm_fault_s, checksum_fail_s})
    );

    assign ck.enc_pos = encoder_position;
    assign ck.fb_pos = feedback_position;
    assign ck.enc_bits = enc_bits;
    assign ck.half_turn = half_turn;
    assign ck.amp_on = amp_on_s;
    assign ck.power_up = amp_on_s && !amp_on_prev;
    assign ck.comm_fault = comm_fault_s;
    assign ck.checksum_fail = checksum_fail_s;
    assign ck.virtual_mode = (mode == MODE_VIRTUAL);
    assign ck.homed = homed;

    abs_position_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_monitor (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ck(ck)
    );

    // ********************************************************
    // Mode switch checks
    // ********************************************************
    wire req_rise = control[CTL_REQUEST] && !req_prev;
    wire req_fall = !control[CTL_REQUEST] && req_prev;
    wire any_moving = |axis_start_accept_flags;
    wire no_program = !control[CTL_PROG_REG] || control[CTL_AXIS_MISMATCH];
    wire not_ready = !control[CTL_CTRL_READY] || !control[CTL_MP_READY];
    wire servo_off = !control[CTL_SERVO_ON];
    wire rise_reject = req_rise && (any_moving || no_program || not_ready || servo_off);
    wire fall_reject = req_fall && any_moving;
    wire switch_error = rise_reject || fall_reject;
    wire mode_change = (req_rise && !rise_reject) || (req_fall && !fall_reject);
    wire write_axis_info = switch_error && (any_moving || no_program);
    // Checked in a fixed order: axes still moving, program, readiness, servo-on.
    wire [15:0] next_switch_code = any_moving ? (req_rise ? ERR_NOT_STOPPED : ERR_RETURN_NOT_STOPPED)
        : no_program ? ERR_NO_PROGRAM
        : not_ready ? ERR_NOT_READY
        : ERR_SERVO_OFF;
    // Axis information names the axes still moving; a program fault clears it.
    wire [31:0] next_axis_info = any_moving ? axis_start_accept_flags : 32'h0;
    wire [IRQ_WIDTH-1:0] irq_events = {mode_change, ck.err_valid, switch_error};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= '0;
            axis_start_accept_flags <= 32'h0;
            enc_bits <= ENC_BITS_RESET;
            half_turn <= HALF_TURN_RESET;
            irq_mask <= '0;
            req_prev <= 1'b0;
            amp_on_prev <= 1'b0;
        end else begin
            control <= wr_control ? hwdata[CTL_WIDTH-1:0] : control;
            axis_start_accept_flags <= wr_start ? hwdata : axis_start_accept_flags;
            enc_bits <= wr_enc_bits ? hwdata[5:0] : enc_bits;
            half_turn <= wr_half_turn ? hwdata : half_turn;
            irq_mask <= wr_irq_mask ? hwdata[IRQ_WIDTH-1:0] : irq_mask;
            req_prev <= control[CTL_REQUEST];
            amp_on_prev <= amp_on_s;
        end
    end

    // An error that lands in the same cycle as a clearing write is kept.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_REAL;
            mode_switch_error_code <= ERR_NONE;
            error_axis_info_low <= 16'h0;
            error_axis_info_high <= 16'h0;
        end else begin
            mode <= mode_change ? (req_rise ? MODE_VIRTUAL : MODE_REAL) : mode;
            mode_switch_error_code <= switch_error ? next_switch_code
                : (wr_switch_err ? ERR_NONE : mode_switch_error_code);
            error_axis_info_low <= write_axis_info ? next_axis_info[15:0] : error_axis_info_low;
            error_axis_info_high <= write_axis_info ? next_axis_info[31:16] : error_axis_info_high;
        end
    end

    // ********************************************************
    // Module errors and interrupts
    // ********************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            module_error_code <= ERR_NONE;
            homing_request <= 1'b0;
            homed <= 1'b0;
            irq_status <= '0;
        end else begin
            module_error_code <= ck.err_valid ? ck.err_code : (wr_module_err ? ERR_NONE : module_error_code);
            homing_request <= ck.homing_set || (homing_request && !homing_done);
            homed <= (homed || homing_done) && !(ck.power_up && ck.comm_fault);
            irq_status <= irq_events | (irq_status & ~(wr_irq_status ? hwdata[IRQ_WIDTH-1:0] : '0));
        end
    end

    // ********************************************************
    // Status outputs
    // ********************************************************
    assign virtual_mode = (mode == MODE_VIRTUAL);
    assign irq = |(irq_status & irq_mask);

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_moving_rise_code: assert property (req_rise && any_moving
        |=> mode_switch_error_code == ERR_NOT_STOPPED && mode == MODE_REAL)
        else $error("Rise with moving axes not rejected with 0001.");

    chk_moving_info_write: assert property (req_rise && any_moving
        |=> {error_axis_info_high, error_axis_info_low} == $past(axis_start_accept_flags))
        else $error("Moving axes not stored in the axis information.");

    chk_moving_fall_code: assert property (req_fall && any_moving && mode == MODE_VIRTUAL
        |=> mode_switch_error_code == ERR_RETURN_NOT_STOPPED && mode == MODE_VIRTUAL)
        else $error("Fall with moving axes not rejected with 0100.");

    chk_fall_enters_real: assert property (req_fall && !fall_reject
        |=> mode == MODE_REAL)
        else $error("Accepted fall did not return to real operation.");

    chk_no_program_code: assert property (req_rise && !any_moving && !control[CTL_PROG_REG]
        |=> mode_switch_error_code == ERR_NO_PROGRAM)
        else $error("Missing program not rejected with 0200.");

    chk_program_info_clear: assert property (req_rise && !any_moving && no_program
        |=> error_axis_info_low == 16'h0 && error_axis_info_high == 16'h0)
        else $error("Axis information not cleared for 0200.");

    chk_axis_mismatch_code: assert property (req_rise && !any_moving && control[CTL_AXIS_MISMATCH]
        |=> mode_switch_error_code == ERR_NO_PROGRAM)
        else $error("Axis mismatch not rejected with 0200.");

    chk_not_ready_code: assert property (req_rise && !any_moving && !no_program && not_ready
        |=> mode_switch_error_code == ERR_NOT_READY)
        else $error("Not ready not rejected with 0201.");

    chk_servo_off_code: assert property (req_rise && !any_moving && !no_program && !not_ready && servo_off
        |=> mode_switch_error_code == ERR_SERVO_OFF)
        else $error("Servo off not rejected with 0202.");

    chk_info_untouched: assert property (switch_error && !any_moving && !no_program
        |=> $stable(error_axis_info_low) && $stable(error_axis_info_high))
        else $error("Axis information written for 0201 or 0202.");

    chk_reject_keeps_mode: assert property (switch_error |=> $stable(mode) ##1 $stable(mode) || mode_change)
        else $error("Rejected request changed the mode.");

    chk_rise_enters_virtual: assert property (req_rise && !rise_reject
        |=> mode == MODE_VIRTUAL)
        else $error("Accepted rise did not enter virtual operation.");

    chk_homing_raised: assert property (ck.homing_set
        |=> homing_request)
        else $error("Homing request not raised.");

    chk_comm_clears_homed: assert property (ck.power_up && ck.comm_fault
        |=> !homed)
        else $error("Communication fault left the axis homed.");

    chk_module_code_kept: assert property (ck.err_valid
        |=> module_error_code == $past(ck.err_code))
        else $error("Module error code not stored.");

    cov_enter_virtual: cover property (req_rise && !rise_reject ##1 mode == MODE_VIRTUAL);
    cov_return_real: cover property (mode == MODE_VIRTUAL && req_fall && !fall_reject);
    cov_module_error: cover property (ck.err_valid && irq);
    cov_switch_reject: cover property (switch_error ##1 irq_status[IRQ_SWITCH_ERR]);
endmodule

/* File: mode_check_pkg.sv */
package mode_check_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_INTERVAL_NS = 3500000;
    localparam int SAMPLE_CYCLES_DEFAULT = SAMPLE_INTERVAL_NS / CLK_PERIOD_NS;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_START_ACCEPT = 8'h04;
    localparam logic [7:0] OFS_STATE = 8'h08;
    localparam logic [7:0] OFS_SWITCH_ERROR = 8'h0C;
    localparam logic [7:0] OFS_INFO_LOW = 8'h10;
    localparam logic [7:0] OFS_INFO_HIGH = 8'h14;
    localparam logic [7:0] OFS_MODULE_ERROR = 8'h18;
    localparam logic [7:0] OFS_ENC_BITS = 8'h1C;
    localparam logic [7:0] OFS_HALF_TURN = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CTL_REQUEST = 0;
    localparam int CTL_CTRL_READY = 1;
    localparam int CTL_MP_READY = 2;
    localparam int CTL_SERVO_ON = 3;
    localparam int CTL_PROG_REG = 4;
    localparam int CTL_AXIS_MISMATCH = 5;
    localparam int CTL_HOMING_DONE = 6;
    localparam int CTL_WIDTH = 6;
    localparam int IRQ_SWITCH_ERR = 0;
    localparam int IRQ_MODULE_ERR = 1;
    localparam int IRQ_MODE_CHANGE = 2;
    localparam int IRQ_WIDTH = 3;

    // ********************************************************
    // Reset values and codes
    // ********************************************************
    localparam logic [5:0] ENC_BITS_RESET = 6'h20;
    localparam logic [5:0] ENC_BITS_FULL = 6'h20;
    localparam logic [31:0] HALF_TURN_RESET = 32'h0000_8000;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_NOT_STOPPED = 16'h0001;
    localparam logic [15:0] ERR_RETURN_NOT_STOPPED = 16'h0100;
    localparam logic [15:0] ERR_NO_PROGRAM = 16'h0200;
    localparam logic [15:0] ERR_NOT_READY = 16'h0201;
    localparam logic [15:0] ERR_SERVO_OFF = 16'h0202;
    localparam logic [15:0] ERR_BACKUP_SUM = 16'h2EEA;
    localparam logic [15:0] ERR_ENC_COMM = 16'h2EF4;
    localparam logic [15:0] ERR_ENC_JUMP = 16'h2EFE;
    localparam logic [15:0] ERR_ENC_MISMATCH = 16'h2F08;

    typedef enum logic {MODE_REAL, MODE_VIRTUAL} op_mode_t;

endpackage

/* File: axis_check_if.sv */
`timescale 1ns/1ps
interface axis_check_if;
    logic [31:0] enc_pos;
    logic [31:0] fb_pos;
    logic [5:0] enc_bits;
    logic [31:0] half_turn;
    logic amp_on;
    logic power_up;
    logic comm_fault;
    logic checksum_fail;
    logic virtual_mode;
    logic homed;
    logic err_valid;
    logic [15:0] err_code;
    logic homing_set;
    modport ctl (output enc_pos, fb_pos, enc_bits, half_turn, amp_on, power_up, comm_fault, checksum_fail,
        virtual_mode, homed, input err_valid, err_code, homing_set);
    modport mon (input enc_pos, fb_pos, enc_bits, half_turn, amp_on, power_up, comm_fault, checksum_fail,
        virtual_mode, homed, output err_valid, err_code, homing_set);
endinterface

/* File: pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // A change is taken only once the second and third stages agree, which filters one-cycle glitches.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            pin_out <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            pin_out <= (stage2 == stage3) ? stage3 : pin_out;
        end
    end
endmodule

/* File: abs_position_monitor.sv */
`timescale 1ns/1ps
module abs_position_monitor #(
    parameter int SAMPLE_CYCLES = mode_check_pkg::SAMPLE_CYCLES_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Axis supervision
    axis_check_if.mon ck
);
    import mode_check_pkg::*;

    logic [31:0] sample_cnt;
    logic [31:0] prev_enc;
    logic mismatch_q;
    wire tick = (sample_cnt == 32'(SAMPLE_CYCLES - 1));
    wire [31:0] enc_mask = (ck.enc_bits >= ENC_BITS_FULL) ? 32'hFFFF_FFFF : ((32'h1 << ck.enc_bits) - 32'h1);
    wire [31:0] step_fwd = (ck.enc_pos - prev_enc) & enc_mask;
    wire [31:0] step_rev = (prev_enc - ck.enc_pos) & enc_mask;
    wire [31:0] step = (step_fwd < step_rev) ? step_fwd : step_rev;
    wire mismatch = ck.amp_on && (((ck.enc_pos ^ ck.fb_pos) & enc_mask) != 32'h0);
    wire ev_backup = ck.power_up && ck.virtual_mode && (ck.checksum_fail || !ck.homed);
    wire ev_comm = ck.power_up && ck.comm_fault;
    wire ev_jump = ck.amp_on && tick && (step > ck.half_turn);
    wire ev_mismatch = mismatch && !mismatch_q;

    // ********************************************************
    // Supervision
    // ********************************************************
    // The mismatch is reported on its onset only, so a lasting fault does not flood the interrupt.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_cnt <= 32'h0;
            prev_enc <= 32'h0;
            mismatch_q <= 1'b0;
            ck.err_valid <= 1'b0;
            ck.err_code <= ERR_NONE;
            ck.homing_set <= 1'b0;
        end else begin
            sample_cnt <= tick ? 32'h0 : sample_cnt + 32'h1;
            prev_enc <= tick ? ck.enc_pos : prev_enc;
            mismatch_q <= mismatch;
            ck.err_valid <= ev_backup | ev_comm | ev_jump | ev_mismatch;
            ck.homing_set <= ev_backup | ev_comm | ev_jump;
            ck.err_code <= ev_backup ? ERR_BACKUP_SUM : ev_comm ? ERR_ENC_COMM : ev_jump ? ERR_ENC_JUMP :
                ev_mismatch ? ERR_ENC_MISMATCH : ck.err_code;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_backup_sum_error: assert property (ck.power_up && ck.virtual_mode && !ck.homed
        |=> ck.err_valid && ck.homing_set && ck.err_code == ERR_BACKUP_SUM)
        else $error("Backup sum error not reported.");
    chk_comm_fault_error: assert property (ck.power_up && ck.comm_fault && !ev_backup
        |=> ck.homing_set && ck.err_code == ERR_ENC_COMM)
        else $error("Encoder communication error not reported.");
    chk_jump_error: assert property (ev_jump && !ck.power_up
        |=> ck.homing_set && ck.err_code == ERR_ENC_JUMP)
        else $error("Encoder jump not reported.");
    chk_mismatch_onset: assert property ($rose(mismatch) && !ck.power_up && !ev_jump
        |=> ck.err_valid && !ck.homing_set && ck.err_code == ERR_ENC_MISMATCH)
        else $error("Encoder mismatch not reported.");
endmodule

/* File: seq_program_model.sv */
`timescale 1ns/1ps
module seq_program_model (
    // Clock
    input wire logic ref_clk,
    // AHB-Lite master
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // ****************
    // Bus transfers
    // ****************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Waits are bounded so a hung slave ends as a failed transfer, not a stuck run.
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd,
        output bit ok);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, ofs};
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        rd = hrdata;
        ok = n < 64;
    endtask
    // Control bits go out with the request low first, then the request rises.
    task automatic request(input logic [31:0] c, output bit ok);
        logic [31:0] r;
        bit ok1;
        xfer(1'b1, 8'h00, c & 32'hFFFF_FFFE, r, ok1);
        xfer(1'b1, 8'h00, c, r, ok);
        ok = ok & ok1;
    endtask
endmodule

/* File: tb_mode_switch_error_check.sv */
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
        end \
    end
module tb_mode_switch_error_check;
    import mode_check_pkg::*;
    logic ref_clk, rst_n, hsel, hwrite, hready, hresp, amp, comm, csum, homing, vmode, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, enc, fb, sa, info, rnd;
    logic [15:0] e;
    logic [7:0] ctls [6];
    int bad_count, total_checks;
    mode_switch_error_check #(.SAMPLE_CYCLES(16)) mode_switch_error_check_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .amp_power_on(amp),
        .encoder_comm_fault(comm), .backup_checksum_fail(csum), .encoder_position(enc),
        .feedback_position(fb), .homing_request(homing), .virtual_mode(vmode), .irq(irq));
    seq_program_model seq_program_model_i (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    // ****************
    // Helpers and reference model
    // ****************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic stop_if(input bit ok);
        if (!ok) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bit ok;
        seq_program_model_i.xfer(1'b1, a, d, r, ok);
        stop_if(ok);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        bit ok;
        seq_program_model_i.xfer(1'b0, a, 32'h0, r, ok);
        stop_if(ok);
        `CHK(r, x)
    endtask
    task automatic req(input logic [31:0] c);
        bit ok;
        seq_program_model_i.request(c, ok);
        stop_if(ok);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Stop check comes first because it also fills the axis information.
    function automatic logic [15:0] exp_rise(input logic [7:0] c, input logic [31:0] s);
        if (s != 0) return ERR_NOT_STOPPED;
        if (!c[CTL_PROG_REG] || c[CTL_AXIS_MISMATCH]) return ERR_NO_PROGRAM;
        if (!c[CTL_CTRL_READY] || !c[CTL_MP_READY]) return ERR_NOT_READY;
        if (!c[CTL_SERVO_ON]) return ERR_SERVO_OFF;
        return ERR_NONE;
    endfunction
    // ****************
    // Stimulus
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end
    initial begin
        {rst_n, amp, comm, csum, enc, fb, info} = '0;
        rnd = $urandom(32'h7d6de448);
        ctls = '{8'h0F, 8'h1F, 8'h1D, 8'h1B, 8'h17, 8'h3F};
        settle(10);
        rst_n <= 1'b1;
        settle(1);
        `CHK(hresp, 1'b0)
        rc(OFS_ENC_BITS, 32'h20);
        rc(OFS_HALF_TURN, 32'h8000);
        wr(8'hFC, 32'hFFFF_FFFF);
        rc(8'hFC, 32'h0);
        for (int i = 0; i < 6; i++) begin
            sa = (i == 1) ? (rnd | 32'h1) : 32'h0;
            wr(OFS_START_ACCEPT, sa);
            req({24'h0, ctls[i]});
            e = exp_rise(ctls[i], sa);
            if (e == ERR_NOT_STOPPED) info = sa;
            if (e == ERR_NO_PROGRAM) info = 32'h0;
            rc(OFS_SWITCH_ERROR, {16'h0, e});
            rc(OFS_INFO_LOW, {16'h0, info[15:0]});
            rc(OFS_INFO_HIGH, {16'h0, info[31:16]});
            `CHK(vmode, 1'b0)
        end
        wr(OFS_IRQ_STATUS, 32'h7);
        req(32'h1F);
        settle(2);
        `CHK(vmode, 1'b1)
        `CHK(irq, 1'b0)
        rc(OFS_IRQ_STATUS, 32'h4);
        wr(OFS_IRQ_MASK, 32'h4);
        settle(2);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_STATUS, 32'h4);
        settle(2);
        `CHK(irq, 1'b0)
        sa = $urandom | 32'h1;
        wr(OFS_START_ACCEPT, sa);
        wr(OFS_CONTROL, 32'h1E);
        rc(OFS_SWITCH_ERROR, {16'h0, ERR_RETURN_NOT_STOPPED});
        rc(OFS_INFO_HIGH, {16'h0, sa[31:16]});
        `CHK(vmode, 1'b1)
        csum <= 1'b1;
        amp <= 1'b1;
        settle(10);
        rc(OFS_MODULE_ERROR, {16'h0, ERR_BACKUP_SUM});
        `CHK(homing, 1'b1)
        wr(OFS_START_ACCEPT, 32'h0);
        req(32'h1F);
        wr(OFS_CONTROL, 32'h1E);
        wr(OFS_CONTROL, 32'h5E);
        settle(2);
        `CHK(vmode, 1'b0)
        `CHK(homing, 1'b0)
        rc(OFS_STATE, 32'hC);
        {amp, csum, comm} <= 3'b001;
        settle(8);
        amp <= 1'b1;
        settle(10);
        rc(OFS_MODULE_ERROR, {16'h0, ERR_ENC_COMM});
        `CHK(homing, 1'b1)
        comm <= 1'b0;
        wr(OFS_MODULE_ERROR, 32'h0);
        enc <= 32'h10000;
        fb <= 32'h10000;
        settle(40);
        rc(OFS_MODULE_ERROR, {16'h0, ERR_ENC_JUMP});
        wr(OFS_MODULE_ERROR, 32'h0);
        fb <= 32'h10001;
        settle(4);
        rc(OFS_MODULE_ERROR, {16'h0, ERR_ENC_MISMATCH});
        complete_run();
    end
endmodule
